// [design/adc_conversion_control.sv]
// Control-pin logic of a SAR converter: conversion start, abort, power-down,
// range selection and reference enables, with an APB register view.
// Assumes pins are asynchronous to pclk; APB and clk_en are on pclk.
//
// Overview of operation
// - Reset pin high aborts any conversion in progress.
// - Reset pin high clears every field of the configuration register.
// - Power-down lets a running conversion finish, then blocks starts, low power.
// - Register bus keeps answering while powered down.
// - Falling convert-start edge puts sample-and-hold into hold and starts converting.
// - Range from bipolar and ten-volt: 0-5, 0-10, +-5, +-10.
// - Reference power-down low enables internal reference, high disables it.
// - Buffer power-down low enables buffer; host keeps it low with internal ref.
// - Software mode takes range and power-down from configuration register, ignores those pins.
// - Software mode is serial output select high and hardware select low.
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctl_cfg.svh"

module adc_conversion_control #(
  parameter int CONV_CYCLES = `ADC_CONV_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire adc_ctl_pkg::pins_t pin_in,
  output logic busy,
  output logic sample_hold,
  output logic conv_done,
  output logic low_power,
  output logic [1:0] range_code,
  output logic ref_enable,
  output logic refbuf_enable,
  output logic ref_fault
);
  import adc_ctl_pkg::*;

  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);

  // ========================================================================
  // Pin synchronisers
  pins_t pins_s;

  pin_sync #(
    .WIDTH($bits(pins_t)),
    .INIT(`ADC_PIN_IDLE)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .d(pin_in),
    .q(pins_s)
  );

  logic start_prev_q;
  logic start_fall;
  logic sw_mode;
  logic bip_eff;
  logic ten_eff;
  logic pd_eff;
  cfg_t cfg_q;
  cfg_t cfg_d;

  assign start_fall = start_prev_q & ~pins_s.convert_start_n;
  assign sw_mode = pins_s.serial_output_sel & ~pins_s.hw_config_sel;
  // Range and power-down pins are don't-care in software mode
  assign bip_eff = sw_mode ? cfg_q.bipolar : pins_s.bipolar_sel;
  assign ten_eff = sw_mode ? cfg_q.ten_volt : pins_s.range_ten_volt_sel;
  assign pd_eff = sw_mode ? cfg_q.power_down : pins_s.power_down_in;

  // ========================================================================
  // Conversion sequencer
  conv_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic done_q, done_d;
  logic busy_q, hold_q, lowpwr_q;
  logic [15:0] count_q, count_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    if (pins_s.conv_reset_in) begin
      // Abort drops the result: no done pulse
      state_d = ST_IDLE;
      cnt_d = '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          // Power-down beats a start in the same cycle
          if (pd_eff) begin
            state_d = ST_POWERED;
          end else if (start_fall) begin
            state_d = ST_CONVERT;
            cnt_d = CONV_LAST;
          end
        end
        ST_CONVERT: begin
          if (cnt_q == '0) begin
            done_d = 1'b1;
            state_d = pd_eff ? ST_POWERED : ST_IDLE;
          end else begin
            cnt_d = cnt_q - CW'(1);
          end
        end
        ST_POWERED: begin
          if (!pd_eff) begin
            state_d = ST_IDLE;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
    count_d = done_d ? count_q + 16'h0001 : count_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
      hold_q <= 1'b0;
      lowpwr_q <= 1'b0;
      start_prev_q <= 1'b1;
      count_q <= 16'h0000;
    end else if (clk_en) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
      busy_q <= (state_d == ST_CONVERT);
      hold_q <= (state_d == ST_CONVERT);
      lowpwr_q <= (state_d == ST_POWERED);
      start_prev_q <= pins_s.convert_start_n;
      count_q <= count_d;
    end
  end

  // ========================================================================
  // Range and reference controls
  logic [1:0] range_q;
  logic refen_q, bufen_q, fault_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_q <= 2'h0;
      refen_q <= 1'b0;
      bufen_q <= 1'b0;
      fault_q <= 1'b0;
    end else if (clk_en) begin
      range_q <= {bip_eff, ten_eff};
      refen_q <= ~pins_s.ref_power_down_in;
      bufen_q <= ~pins_s.refbuf_power_down_in;
      // Internal reference without its buffer is a board fault worth flagging
      fault_q <= ~pins_s.ref_power_down_in & pins_s.refbuf_power_down_in;
    end
  end

  // ========================================================================
  // APB slave: one wait state, never gated by power-down
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [31:0] status;
  logic hit;

  always_comb begin
    status = 32'h0000_0000;
    status[`ADC_ST_BUSY_BIT] = busy_q;
    status[`ADC_ST_LOWPWR_BIT] = lowpwr_q;
    status[`ADC_ST_RANGE_LSB +: 2] = range_q;
    status[`ADC_ST_SWMODE_BIT] = sw_mode;
    status[`ADC_ST_REFEN_BIT] = refen_q;
    status[`ADC_ST_BUFEN_BIT] = bufen_q;
    status[`ADC_ST_REFFAULT_BIT] = fault_q;
  end

  always_comb begin
    hit = (paddr == `ADC_CFG_OFS) || (paddr == `ADC_STATUS_OFS) || (paddr == `ADC_COUNT_OFS);
    pready_d = psel & penable & ~pready_q;
    pslverr_d = pready_d & ~hit;
    prdata_d = 32'h0000_0000;
    if (pready_d && !pwrite) begin
      if (paddr == `ADC_CFG_OFS) begin
        prdata_d[2:0] = cfg_q;
      end else if (paddr == `ADC_STATUS_OFS) begin
        prdata_d = status;
      end else if (paddr == `ADC_COUNT_OFS) begin
        prdata_d[15:0] = count_q;
      end
    end
    cfg_d = cfg_q;
    if (pins_s.conv_reset_in) begin
      // Reset pin outranks a software write in the same cycle
      cfg_d = `ADC_CFG_RESET;
    end else if (psel && penable && pready_q && pwrite && paddr == `ADC_CFG_OFS) begin
      cfg_d.bipolar = pwdata[`ADC_CFG_BIPOLAR_BIT];
      cfg_d.ten_volt = pwdata[`ADC_CFG_TEN_BIT];
      cfg_d.power_down = pwdata[`ADC_CFG_PD_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      cfg_q <= `ADC_CFG_RESET;
    end else if (clk_en) begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      cfg_q <= cfg_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign busy = busy_q;
  assign sample_hold = hold_q;
  assign conv_done = done_q;
  assign low_power = lowpwr_q;
  assign range_code = range_q;
  assign ref_enable = refen_q;
  assign refbuf_enable = bufen_q;
  assign ref_fault = fault_q;

  // ========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  conv_abort_a: assert property (
    clk_en && pins_s.conv_reset_in |=> !busy_q && !done_q)
    else $error("conversion not aborted by reset pin");

  cfg_clear_a: assert property (
    clk_en && pins_s.conv_reset_in |=> cfg_q == `ADC_CFG_RESET)
    else $error("configuration not cleared by reset pin");

  pd_finish_a: assert property (
    clk_en && state_q == ST_CONVERT && cnt_q != '0 && !pins_s.conv_reset_in
    |=> busy_q && state_q == ST_CONVERT)
    else $error("power-down cut a running conversion");

  pd_nostart_a: assert property (
    state_q == ST_POWERED |=> !$rose(busy_q))
    else $error("conversion started while powered down");

  bus_alive_a: assert property (
    clk_en && psel && penable && !pready_q |=> pready_q)
    else $error("bus did not answer");

  start_hold_a: assert property (
    clk_en && start_fall && state_q == ST_IDLE && !pd_eff && !pins_s.conv_reset_in
    |=> busy_q && sample_hold && cnt_q == CONV_LAST)
    else $error("start edge did not begin conversion");

  range_map_a: assert property (
    clk_en |=> range_q == {$past(bip_eff), $past(ten_eff)})
    else $error("range code mismatch");

  ref_enable_a: assert property (
    clk_en |=> ref_enable == !$past(pins_s.ref_power_down_in))
    else $error("reference enable mismatch");

  sw_config_a: assert property (
    clk_en && sw_mode |=> range_q == {$past(cfg_q.bipolar), $past(cfg_q.ten_volt)})
    else $error("software range not applied");

  idle_after_a: assert property (
    $fell(pins_s.conv_reset_in) |-> state_q == ST_IDLE && !busy_q)
    else $error("not idle after reset release");

  conv_done_c: cover property (busy_q ##[1:100] conv_done);
  conv_abort_c: cover property (busy_q ##1 pins_s.conv_reset_in);
  pd_after_c: cover property (busy_q && pd_eff ##[1:100] low_power);
  sw_write_c: cover property (psel && penable && pready_q && pwrite && sw_mode);

endmodule // adc_conversion_control

`default_nettype wire

// [design/adc_ctl_cfg.svh]
// Offsets, field positions, reset values and timing counts of the converter control block.
// Assumes an APB slave with 32-bit data and byte addresses on a 20 MHz pclk.
`ifndef ADC_CTL_CFG_SVH
`define ADC_CTL_CFG_SVH

// ==========================================================================
// Register map
`define ADC_ADDR_W 12
`define ADC_CFG_OFS 12'h000
`define ADC_STATUS_OFS 12'h004
`define ADC_COUNT_OFS 12'h008

// ==========================================================================
// Configuration register fields
`define ADC_CFG_BIPOLAR_BIT 0
`define ADC_CFG_TEN_BIT 1
`define ADC_CFG_PD_BIT 2
`define ADC_CFG_RESET 3'h0

// ==========================================================================
// Status register fields
`define ADC_ST_BUSY_BIT 0
`define ADC_ST_LOWPWR_BIT 1
`define ADC_ST_RANGE_LSB 2
`define ADC_ST_SWMODE_BIT 4
`define ADC_ST_REFEN_BIT 5
`define ADC_ST_BUFEN_BIT 6
`define ADC_ST_REFFAULT_BIT 7

// ==========================================================================
// Pin idle levels after reset: convert-start idles high
`define ADC_PIN_IDLE 9'h001

// ==========================================================================
// Timing
`define ADC_CLK_PERIOD_NS 50
`define ADC_CONV_TIME_NS 1000
`define ADC_CONV_CYCLES ((`ADC_CONV_TIME_NS + `ADC_CLK_PERIOD_NS - 1) / `ADC_CLK_PERIOD_NS)

`endif

// [design/adc_ctl_pkg.sv]
// Types shared by the converter control block.
// Assumes the constants of adc_ctl_cfg.svh for every number.
package adc_ctl_pkg;

  // ========================================================================
  // Control pins as seen from outside, convert_start_n in bit 0
  typedef struct packed {
    logic conv_reset_in;
    logic power_down_in;
    logic bipolar_sel;
    logic range_ten_volt_sel;
    logic ref_power_down_in;
    logic refbuf_power_down_in;
    logic serial_output_sel;
    logic hw_config_sel;
    logic convert_start_n;
  } pins_t;

  // ========================================================================
  // Serial configuration register
  typedef struct packed {
    logic power_down;
    logic ten_volt;
    logic bipolar;
  } cfg_t;

  // ========================================================================
  // Conversion sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONVERT = 2'b01,
    ST_POWERED = 2'b10
  } conv_state_t;

endpackage

// [design/pin_sync.sv]
// Two-stage synchroniser for a group of asynchronous pin inputs.
// Assumes pins may change at any time relative to pclk.
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 9,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // ========================================================================
  // One pair of flops per pin
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q <= INIT[i];
          sync_q <= INIT[i];
        end else if (clk_en) begin
          meta_q <= d[i];
          sync_q <= meta_q;
        end
      end
      assign q[i] = sync_q;
    end
  endgenerate

endmodule // pin_sync

`default_nettype wire

// [testbench/host_model.sv]
// Host controller model that drives the converter control pins.
// Assumes it is driven from tb_top tasks; pins change only after pclk rises.
`timescale 1ns/10ps
`default_nettype none

module host_model (
  input wire logic pclk,
  output var adc_ctl_pkg::pins_t pins
);
  import adc_ctl_pkg::*;
  initial pins = 9'h001;
  // ==========================================================
  // Start strobe, one cycle low is enough for the synchroniser
  task start();
    @(posedge pclk);
    pins.convert_start_n <= 1'b0;
    @(posedge pclk);
    pins.convert_start_n <= 1'b1;
  endtask
  // ==========================================================
  // Level pins; buffer kept on while the internal reference is on
  task set(input logic [8:0] v);
    pins_t p;
    p = v;
    p.refbuf_power_down_in = p.refbuf_power_down_in & p.ref_power_down_in;
    p.convert_start_n = pins.convert_start_n;
    @(posedge pclk);
    pins <= p;
  endtask
endmodule // host_model

`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the converter control block.
// Assumes host_model drives the pins and the bench is the APB master.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import adc_ctl_pkg::*;
  localparam int CC = 6;
  logic pclk, presetn, clk_en, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er, busy, sample_hold, conv_done, low_power;
  logic ref_enable, refbuf_enable, ref_fault;
  logic [1:0] range_code;
  pins_t pin_in;
  int err_total, checks_done, cyc, dones, convs;

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  adc_conversion_control #(.CONV_CYCLES(CC)) DUT (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .busy(busy), .sample_hold(sample_hold), .conv_done(conv_done),
    .low_power(low_power), .range_code(range_code), .ref_enable(ref_enable),
    .refbuf_enable(refbuf_enable), .ref_fault(ref_fault));
  host_model HOST (.pclk(pclk), .pins(pin_in));

  // ==========================================================
  // Timeout and completion monitor
  always @(posedge pclk) begin
    cyc++;
    if (conv_done === 1'b1) dones++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task wt(input int n);
    repeat (n) @(negedge pclk);
  endtask

  // ==========================================================
  // APB master: request held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pready", 1, pready);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits for busy to rise, then returns its length in cycles
  task wait_busy(output int b);
    int n;
    n = 0;
    b = 0;
    while (busy !== 1'b1 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    while (busy === 1'b1 && b < 50) begin
      @(negedge pclk);
      b++;
    end
  endtask

  task t_reset();
    chk("busy", 0, busy);
    apb(0, 12'h000, 0);
    chk("cfg", 0, rd);
    apb(0, 12'h004, 0);
    chk("status", 32'h0000_0060, rd);
    $display("reset test done");
  endtask

  task t_conv();
    int b;
    repeat (2) begin
      HOST.start();
      wait_busy(b);
      chk("busy len", CC, b);
      chk("done", 1, conv_done);
      convs++;
    end
    apb(0, 12'h008, 0);
    chk("count", convs, rd);
    $display("conversion test done");
  endtask

  task t_range();
    for (int i = 0; i < 4; i++) begin
      HOST.set(9'(i << 5));
      wt(4);
      chk("range", i, range_code);
    end
    $display("range test done");
  endtask

  task t_ref();
    HOST.set(9'h010);
    wt(4);
    chk("ref en", 0, ref_enable);
    chk("buf en", 1, refbuf_enable);
    chk("ref fault", 0, ref_fault);
    HOST.set(9'h018);
    wt(4);
    chk("buf off", 0, refbuf_enable);
    HOST.set(9'h000);
    wt(4);
    chk("ref on", 1, ref_enable);
    $display("reference test done");
  endtask

  task t_pd();
    int b;
    HOST.start();
    wt(4);
    HOST.set(9'h080);
    wait_busy(b);
    convs++;
    chk("pd finish", 1, conv_done);
    wt(2);
    chk("low power", 1, low_power);
    HOST.start();
    wt(8);
    chk("pd start", 0, busy);
    apb(0, 12'h004, 0);
    chk("pd status", 32'h0000_0062, rd);
    HOST.set(9'h000);
    wt(4);
    chk("pd off", 0, low_power);
    $display("power-down test done");
  endtask

  task t_sw();
    HOST.set(9'h084);
    apb(1, 12'h000, 32'h0000_0003);
    wt(4);
    chk("sw range", 3, range_code);
    chk("sw pd pin", 0, low_power);
    apb(0, 12'h004, 0);
    chk("sw status", 32'h0000_007c, rd);
    HOST.set(9'h086);
    wt(4);
    chk("hw pd pin", 1, low_power);
    HOST.set(9'h184);
    wt(4);
    HOST.set(9'h004);
    wt(4);
    apb(0, 12'h000, 0);
    chk("cfg clear", 0, rd);
    chk("range clear", 0, range_code);
    HOST.set(9'h000);
    wt(4);
    $display("software mode test done");
  endtask

  task t_abort();
    int n;
    HOST.start();
    wt(4);
    chk("abort busy", 1, busy);
    chk("abort hold", 1, sample_hold);
    n = dones;
    HOST.set(9'h100);
    wt(4);
    chk("abort", 0, busy);
    HOST.set(9'h000);
    wt(CC + 4);
    chk("no done", n, dones);
    apb(0, 12'h008, 0);
    chk("count", convs, rd);
    apb(0, 12'h00c, 0);
    chk("unmapped err", 1, er);
    chk("unmapped data", 0, rd);
    $display("abort test done");
  endtask

  // Clock enable low must freeze a running conversion, not lose it
  task t_freeze();
    int n;
    HOST.start();
    wt(4);
    n = dones;
    @(posedge pclk);
    clk_en <= 1'b0;
    wt(CC + 4);
    chk("frozen busy", 1, busy);
    chk("frozen done", n, dones);
    @(posedge pclk);
    clk_en <= 1'b1;
    wt(CC + 2);
    chk("thawed busy", 0, busy);
    chk("thawed done", n + 1, dones);
    convs++;
    $display("clock enable test done");
  endtask

  // Bus reset in mid-conversion: no result may survive it
  task t_rst2();
    int n;
    HOST.start();
    wt(4);
    n = dones;
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    wt(2);
    chk("rst busy", 0, busy);
    chk("rst hold", 0, sample_hold);
    wt(CC + 2);
    chk("rst done", n, dones);
    apb(0, 12'h008, 0);
    chk("rst count", 0, rd);
    $display("mid-run reset test done");
  endtask

  initial begin
    presetn <= 1'b0;
    clk_en <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0000_0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    wt(4);
    t_reset();
    t_conv();
    t_range();
    t_ref();
    t_pd();
    t_sw();
    t_abort();
    t_freeze();
    t_rst2();
    tally_and_finish();
  end
endmodule // tb_top

`default_nettype wire
